// *** ltf_pkg.sv ***
// Package for the laser tuning flag latch block: register map, fields, resets
package ltf_pkg;

    // Lane count covered by one bank
    localparam int LTF_LANES = 8;
    localparam int LTF_NFLAG = 6;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] LTF_IDX_STATUS = 8'hDE;  // Live status, one byte per lane
    localparam logic [7:0] LTF_IDX_SUMMARY = 8'hE6; // Flag summary, one bit per lane
    localparam logic [7:0] LTF_IDX_FLAGS = 8'hE7;   // Latched flags, one byte per lane
    localparam logic [7:0] LTF_IDX_MASK = 8'hEF;    // Flag masks, one byte per lane

    // Live status byte fields
    localparam int LTF_ST_LOCK_LOST = 0;
    localparam int LTF_ST_BUSY = 1;

    // Flag byte fields
    localparam int LTF_FL_TUNE_DONE = 0;
    localparam int LTF_FL_LOCK_LOST = 1;
    localparam int LTF_FL_BAD_CHAN = 2;
    localparam int LTF_FL_REJECT = 3;
    localparam int LTF_FL_FINE_OOR = 4;
    localparam int LTF_FL_POWER_OOR = 5;

    // Reset values
    localparam logic [5:0] LTF_FLAG_RST = 6'h00;
    localparam logic [5:0] LTF_MASK_RST = 6'h3F;
    localparam logic [31:0] LTF_RDATA_RST = 32'h0000_0000;

    // AHB-Lite encodings used by the slave
    localparam logic [1:0] LTF_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] LTF_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] LTF_HSIZE_WORD = 3'h2;
    localparam logic LTF_HRESP_OKAY = 1'b0;

    // State of the block, apart from the summary, ready and response output flops
    typedef struct packed {
        logic [LTF_LANES-1:0][LTF_NFLAG-1:0] flags; // Latched flags per lane
        logic [LTF_LANES-1:0][LTF_NFLAG-1:0] mask;  // Interrupt masks per lane
        logic [LTF_LANES-1:0] busy;                 // Registered tuning busy
        logic [LTF_LANES-1:0] lock_lost;            // Registered lock lost
        logic wr_pend;                              // Write data phase due
        logic [7:0] wr_idx;                         // Index of pending write
        logic [31:0] rdata;                         // Read data for data phase
        logic irq;                                  // Interrupt level
    } ltf_state_t;

    localparam ltf_state_t LTF_STATE_RST = '{
        flags: {LTF_LANES{LTF_FLAG_RST}},
        mask: {LTF_LANES{LTF_MASK_RST}},
        busy: '0,
        lock_lost: '0,
        wr_pend: 1'b0,
        wr_idx: 8'h00,
        rdata: LTF_RDATA_RST,
        irq: 1'b0
    };

endpackage : ltf_pkg

// *** ltf_flag_latches.sv ***
// Laser tuning status, latched flags, summary and masks behind an AHB-Lite slave
// Operation
// - Per-lane busy status is high while tuning, fine offset or power settling.
// - Status byte bit 0 shows live lock state, 1 meaning unlocked.
// - Summary bit n-1 is set exactly when lane n has any flag set.
// - Reading a lane flag byte clears its latched flags.
// - Flag bit 5 latches on an out-of-range target power write.
// - Flag bit 4 latches on an out-of-range fine frequency offset.
// - Flag bit 3 latches when a grid or channel change cannot be served.
// - Rejected-tuning flag clears once channel or grid is reprogrammed successfully.
// - Power or offset change during tuning may raise the rejected-tuning flag.
// - Flag bit 2 latches when channel number is outside advertised range.
// - Flag bit 1 latches while the live lock-lost status is high.
// - Flag bit 0 latches when a tuning operation finishes.
// - Per-lane byte arrays place lane 1 at the lowest address.
// - Per-lane bit vectors place lane 1 at bit 0.
// - Mask bits reset to 1; a set mask keeps its flag off the interrupt.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module ltf_flag_latches
    import ltf_pkg::*;
(
    input wire logic I_REF_CLK,                      // 20 MHz clock
    input wire logic I_RESET_N,                      // Async reset, active low
    // AHB-Lite slave
    input wire logic I_HSEL,                         // Slave select
    input wire logic [31:0] I_HADDR,                 // Byte address
    input wire logic [1:0] I_HTRANS,                 // Transfer type
    input wire logic I_HWRITE,                       // Write when high
    input wire logic [2:0] I_HSIZE,                  // Transfer size
    input wire logic I_HREADY,                       // Bus ready
    input wire logic [31:0] I_HWDATA,                // Write data
    output logic [31:0] O_HRDATA,                    // Read data
    output logic O_HREADYOUT,                        // Slave ready
    output logic O_HRESP,                            // Response, always OKAY
    // Laser control side, one bit per lane, lane 1 at bit 0, except I_REJECT_ON_BUSY and O_IRQ
    input wire logic [LTF_LANES-1:0] I_TUNE_BUSY,    // Tuning in progress
    input wire logic [LTF_LANES-1:0] I_LOCK_LOST,    // Wavelength unlocked
    input wire logic [LTF_LANES-1:0] I_POWER_OOR,    // Bad target power written
    input wire logic [LTF_LANES-1:0] I_FINE_OOR,     // Bad fine offset written
    input wire logic [LTF_LANES-1:0] I_TUNE_REJECT,  // Grid/channel change unserved
    input wire logic [LTF_LANES-1:0] I_RETUNE_OK,    // Grid/channel reprogrammed fine
    input wire logic [LTF_LANES-1:0] I_BAD_CHAN,     // Channel out of range
    input wire logic [LTF_LANES-1:0] I_POWER_WR,     // Target power written
    input wire logic [LTF_LANES-1:0] I_FINE_WR,      // Fine offset written
    input wire logic I_REJECT_ON_BUSY,               // Reject writes during tuning
    output logic [LTF_LANES-1:0] O_FLAG_SUMMARY,     // Per-lane summary
    output logic O_IRQ                               // Level interrupt, active high
);

    ltf_state_t st;
    ltf_state_t next_st;

    // Address-phase qualifiers
    logic addr_valid;
    logic [7:0] addr_idx;
    logic rd_req;
    logic wr_req;

    // Index decode into a lane of a per-lane array
    function automatic logic in_array(input logic [7:0] idx, input logic [7:0] base);
        logic [7:0] diff;
        diff = idx - base;
        return (idx >= base) && (diff < 8'(LTF_LANES));
    endfunction : in_array

    // Lane number of an array index
    function automatic logic [2:0] lane_of(input logic [7:0] idx, input logic [7:0] base);
        logic [7:0] diff;
        diff = idx - base;
        return diff[2:0];
    endfunction : lane_of

    // Summary vector from the latched flags
    function automatic logic [LTF_LANES-1:0] summary_of(
        input logic [LTF_LANES-1:0][LTF_NFLAG-1:0] fl
    );
        logic [LTF_LANES-1:0] s;
        s = '0;
        for (int i = 0; i < LTF_LANES; i++) begin
            s[i] = |fl[i];
        end
        return s;
    endfunction : summary_of

    // Bus request decode; writes need whole aligned words, reads take any size or address
    assign addr_valid = I_HSEL && I_HREADY
        && ((I_HTRANS == LTF_HTRANS_NONSEQ) || (I_HTRANS == LTF_HTRANS_SEQ));
    assign addr_idx = I_HADDR[9:2];
    assign rd_req = addr_valid && !I_HWRITE;
    assign wr_req = addr_valid && I_HWRITE && (I_HSIZE == LTF_HSIZE_WORD)
        && (I_HADDR[31:10] == 22'h000000) && (I_HADDR[1:0] == 2'h0);

    // Next state of flags, masks, bus and interrupt
    always_comb begin
        logic [LTF_LANES-1:0][LTF_NFLAG-1:0] set_ev;
        logic [LTF_LANES-1:0] done_ev;
        logic [LTF_LANES-1:0] busy_now;
        logic [2:0] ln;
        logic [31:0] rd;
        logic [LTF_LANES-1:0][LTF_NFLAG-1:0] unmasked;
        set_ev = '0;
        done_ev = '0;
        busy_now = '0;
        ln = 3'h0;
        rd = 32'h0000_0000;
        unmasked = '0;
        next_st = st;

        busy_now = I_TUNE_BUSY;
        next_st.busy = busy_now;
        next_st.lock_lost = I_LOCK_LOST;
        done_ev = st.busy & ~busy_now;

        // Collect set events per lane
        for (int i = 0; i < LTF_LANES; i++) begin
            set_ev[i][LTF_FL_POWER_OOR] = I_POWER_OOR[i];
            set_ev[i][LTF_FL_FINE_OOR] = I_FINE_OOR[i];
            set_ev[i][LTF_FL_REJECT] = I_TUNE_REJECT[i]
                || (I_REJECT_ON_BUSY && st.busy[i] && (I_POWER_WR[i] || I_FINE_WR[i]));
            set_ev[i][LTF_FL_BAD_CHAN] = I_BAD_CHAN[i];
            set_ev[i][LTF_FL_LOCK_LOST] = I_LOCK_LOST[i];
            set_ev[i][LTF_FL_TUNE_DONE] = done_ev[i];
        end

        // Write data phase: only mask bytes are writable
        next_st.wr_pend = 1'b0;
        if (st.wr_pend && in_array(st.wr_idx, LTF_IDX_MASK)) begin
            ln = lane_of(st.wr_idx, LTF_IDX_MASK);
            next_st.mask[ln] = I_HWDATA[LTF_NFLAG-1:0];
        end
        if (wr_req) begin
            next_st.wr_pend = 1'b1;
            next_st.wr_idx = addr_idx;
        end

        // Read data built in address phase, sees a mask write just completing
        if (rd_req) begin
            if (in_array(addr_idx, LTF_IDX_STATUS)) begin
                ln = lane_of(addr_idx, LTF_IDX_STATUS);
                rd[LTF_ST_BUSY] = st.busy[ln];
                rd[LTF_ST_LOCK_LOST] = st.lock_lost[ln];
            end else if (addr_idx == LTF_IDX_SUMMARY) begin
                rd[LTF_LANES-1:0] = summary_of(st.flags);
            end else if (in_array(addr_idx, LTF_IDX_FLAGS)) begin
                ln = lane_of(addr_idx, LTF_IDX_FLAGS);
                rd[LTF_NFLAG-1:0] = st.flags[ln];
                next_st.flags[ln] = LTF_FLAG_RST;
            end else if (in_array(addr_idx, LTF_IDX_MASK)) begin
                ln = lane_of(addr_idx, LTF_IDX_MASK);
                rd[LTF_NFLAG-1:0] = next_st.mask[ln];
            end
        end
        next_st.rdata = rd;

        for (int i = 0; i < LTF_LANES; i++) begin
            if (I_RETUNE_OK[i]) begin
                next_st.flags[i][LTF_FL_REJECT] = 1'b0;
            end
        end

        for (int i = 0; i < LTF_LANES; i++) begin
            next_st.flags[i] = next_st.flags[i] | set_ev[i];
        end

        for (int i = 0; i < LTF_LANES; i++) begin
            unmasked[i] = next_st.flags[i] & ~next_st.mask[i];
        end
        next_st.irq = |unmasked;
    end

    // State register
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st <= LTF_STATE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Summary output kept in its own flops
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_FLAG_SUMMARY <= '0;
            O_HREADYOUT <= 1'b0;
        end else begin
            O_FLAG_SUMMARY <= summary_of(next_st.flags);
            O_HREADYOUT <= 1'b1;
        end
    end

    // Response output in its own flop; read data and interrupt straight from state flops
    always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_HRESP <= LTF_HRESP_OKAY;
        end else begin
            O_HRESP <= LTF_HRESP_OKAY;
        end
    end

    assign O_HRDATA = st.rdata;
    assign O_IRQ = st.irq;

endmodule : ltf_flag_latches

// *** ltf_props.sv ***
// Checker for the tuning flag latches, bound to the top module
`timescale 1ns/100ps
module ltf_props
    import ltf_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RESET_N,
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic I_HREADY,
    input wire logic [7:0] I_POWER_OOR,
    input wire logic [7:0] I_FINE_OOR,
    input wire logic [7:0] I_TUNE_REJECT,
    input wire logic [7:0] I_BAD_CHAN,
    input wire logic [7:0] I_LOCK_LOST,
    input wire logic [7:0] I_TUNE_BUSY,
    input wire logic [31:0] O_HRDATA,
    input wire logic [7:0] O_FLAG_SUMMARY,
    input wire logic O_IRQ
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);
    // Accepted reads, reads of the flag bytes and of lane 1's byte, and lane 1 set events
    wire logic rd_ok = I_HSEL && I_HREADY && I_HTRANS[1] && !I_HWRITE && I_HADDR[31:10] == 0;
    wire logic rd_fl = rd_ok && I_HADDR[9:2] >= LTF_IDX_FLAGS && I_HADDR[9:2] <= 8'hEE;
    wire logic rd_l1 = rd_ok && I_HADDR[9:2] == LTF_IDX_FLAGS;
    wire logic ev_l1 = I_POWER_OOR[0] | I_FINE_OOR[0] | I_TUNE_REJECT[0] | I_BAD_CHAN[0];
    property p_pwr; I_POWER_OOR[0] |=> O_FLAG_SUMMARY[0]; endproperty
    a_pwr: assert property (p_pwr) else $error("power flag not latched");
    property p_fine; I_FINE_OOR[7] |=> O_FLAG_SUMMARY[7]; endproperty
    a_fine: assert property (p_fine) else $error("fine flag not latched");
    property p_rej; I_TUNE_REJECT[3] |=> O_FLAG_SUMMARY[3]; endproperty
    a_rej: assert property (p_rej) else $error("reject flag not latched");
    property p_chan; I_BAD_CHAN[5] |=> O_FLAG_SUMMARY[5]; endproperty
    a_chan: assert property (p_chan) else $error("channel flag not latched");
    property p_lock; I_LOCK_LOST[1] |-> ##[1:2] O_FLAG_SUMMARY[1]; endproperty
    a_lock: assert property (p_lock) else $error("lock flag not latched");
    property p_done; $fell(I_TUNE_BUSY[1]) |-> ##[1:3] O_FLAG_SUMMARY[1]; endproperty
    a_done: assert property (p_done) else $error("done flag not latched");
    property p_irq; O_IRQ |-> O_FLAG_SUMMARY != 8'h00; endproperty
    a_irq: assert property (p_irq) else $error("irq without flag");
    property p_rsv; rd_fl |=> O_HRDATA[31:6] == 26'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag bits set");
    property p_clr; rd_l1 && !ev_l1 && I_TUNE_BUSY[0] == 0 && I_LOCK_LOST[0] == 0
        && $past(I_TUNE_BUSY[0] | I_LOCK_LOST[0]) == 0 && $past(I_TUNE_BUSY[0], 2) == 0
        && $past(I_TUNE_BUSY[0], 3) == 0 |=> !O_FLAG_SUMMARY[0]; endproperty
    a_clr: assert property (p_clr) else $error("flag read did not clear");
endmodule : ltf_props
bind ltf_flag_latches ltf_props i_props (.*);

// *** ltf_host.sv ***
// Host controller model: AHB-Lite master for the flag bank
`timescale 1ns/100ps
module ltf_host
    import ltf_pkg::*;
(
    input wire logic i_clk,          // Bus clock
    input wire logic i_ready,        // Bus ready
    input wire logic [31:0] i_rdata, // Read data
    output logic o_sel,              // Slave select
    output logic [31:0] o_addr,      // Byte address
    output logic [1:0] o_trans,      // Transfer type
    output logic o_write,            // Write when high
    output logic [2:0] o_size,       // Always a word
    output logic [31:0] o_wdata      // Write data
);
    // Idle bus at time zero
    initial begin
        {o_sel, o_addr, o_trans, o_write, o_wdata} = '0;
        o_size = LTF_HSIZE_WORD;
    end
    // One single transfer, address then data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge i_clk);
        {o_sel, o_trans, o_addr, o_write} <= {1'b1, LTF_HTRANS_NONSEQ, a, wr};
        do @(posedge i_clk); while (i_ready !== 1'b1);
        {o_sel, o_trans, o_wdata} <= {1'b0, 2'h0, wd};
        do @(posedge i_clk); while (i_ready !== 1'b1);
        rd = i_rdata;
        o_wdata <= ~wd;
    endtask : xfer
    task automatic service(output logic [7:0] sum);
        logic [31:0] d;
        xfer(1'b0, {22'h0, LTF_IDX_SUMMARY, 2'b00}, 32'h0, d);
        sum = d[7:0];
        for (int l = 0; l < LTF_LANES; l++)
            if (sum[l]) xfer(1'b0, {22'h0, LTF_IDX_FLAGS + 8'(l), 2'b00}, 32'h0, d);
    endtask : service
endmodule : ltf_host

// *** test_ltf_flag_latches.sv ***
// Self-checking bench for the tuning flag latches
`timescale 1ns/100ps
module test_ltf_flag_latches;
    import ltf_pkg::*;
    typedef struct {int lane; int kind; logic [7:0] exp;} ltf_row_t;
    logic clk, rst_n, rob, sel, wr, rdy, resp, irq;
    logic [6:0][7:0] ev;
    logic [7:0] busy, lock, sum, sv;
    logic [1:0] trans;
    logic [2:0] size;
    logic [31:0] addr, wdata, rdata, d;
    int mismatches = 0;
    int n_tests = 0;
    ltf_row_t rows [4] = '{'{0, 0, 8'h20}, '{7, 1, 8'h10}, '{3, 2, 8'h08}, '{5, 3, 8'h04}};
    ltf_flag_latches i_dut (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_HSEL(sel), .I_HADDR(addr),
        .I_HTRANS(trans), .I_HWRITE(wr), .I_HSIZE(size), .I_HREADY(rdy), .I_HWDATA(wdata),
        .O_HRDATA(rdata), .O_HREADYOUT(rdy), .O_HRESP(resp), .I_TUNE_BUSY(busy),
        .I_LOCK_LOST(lock), .I_POWER_OOR(ev[0]), .I_FINE_OOR(ev[1]), .I_TUNE_REJECT(ev[2]),
        .I_BAD_CHAN(ev[3]), .I_POWER_WR(ev[4]), .I_FINE_WR(ev[5]), .I_RETUNE_OK(ev[6]),
        .I_REJECT_ON_BUSY(rob), .O_FLAG_SUMMARY(sum), .O_IRQ(irq));
    ltf_host i_host (.i_clk(clk), .i_ready(rdy), .i_rdata(rdata), .o_sel(sel), .o_addr(addr),
        .o_trans(trans), .o_write(wr), .o_size(size), .o_wdata(wdata));
    // Clock at 20 MHz
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    function automatic logic [31:0] adr(input logic [7:0] idx, input int l);
        return {22'h0, idx + 8'(l), 2'b00};
    endfunction : adr
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string m);
        i_host.xfer(1'b0, a, 32'h0, d);
        chk(d === e, m);
    endtask : rdchk
    task automatic pulse(input int k, input int l);
        @(posedge clk) ev[k][l] <= 1'b1;
        @(posedge clk) ev[k][l] <= 1'b0;
        #1;
    endtask : pulse
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Main sequence: table rows, then hand-written cases
    initial begin
        {rst_n, rob, ev, busy, lock} = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(adr(LTF_IDX_MASK, 0), 32'h3F, "mask reset");
        foreach (rows[i]) begin
            pulse(rows[i].kind, rows[i].lane);
            chk(sum === 8'(1 << rows[i].lane) && irq === 1'b0, "summary pin");
            chk(resp === LTF_HRESP_OKAY, "response okay");
            rdchk(adr(LTF_IDX_SUMMARY, 0), 32'(1 << rows[i].lane), "summary read");
            rdchk(adr(LTF_IDX_FLAGS, rows[i].lane), 32'(rows[i].exp), "flag");
            rdchk(adr(LTF_IDX_FLAGS, rows[i].lane), 32'h0, "flag cleared");
            chk(sum === 8'h00, "summary cleared");
        end
        @(posedge clk) {busy[1], lock[1]} <= 2'b11;
        rdchk(adr(LTF_IDX_STATUS, 1), 32'h3, "status lane 2");
        rdchk(adr(LTF_IDX_STATUS, 0), 32'h0, "status lane 1");
        @(posedge clk) {busy[1], lock[1]} <= 2'b00;
        repeat (4) @(posedge clk);
        rdchk(adr(LTF_IDX_FLAGS, 1), 32'h3, "done and lock");
        i_host.xfer(1'b1, adr(LTF_IDX_MASK, 0), 32'h0, d);
        pulse(0, 0);
        chk(irq === 1'b1, "irq raised");
        i_host.xfer(1'b1, adr(LTF_IDX_MASK, 0), 32'h3F, d);
        #1 chk(irq === 1'b0, "irq masked");
        i_host.xfer(1'b1, adr(LTF_IDX_FLAGS, 0), 32'hFF, d);
        rdchk(adr(LTF_IDX_FLAGS, 0), 32'h20, "flag write ignored");
        rdchk(32'h0, 32'h0, "unmapped read");
        // Event lands on the same edge as the clearing read of its byte
        fork
            rdchk(adr(LTF_IDX_FLAGS, 0), 32'h0, "read during set");
            begin
                @(posedge clk) ev[0][0] <= 1'b1;
                @(posedge clk) ev[0][0] <= 1'b0;
            end
        join
        rdchk(adr(LTF_IDX_FLAGS, 0), 32'h20, "set wins over clear");
        @(posedge clk) {busy[2], rob} <= 2'b11;
        pulse(5, 2);
        chk(sum[2] === 1'b1, "reject on busy");
        pulse(6, 2);
        chk(sum[2] === 1'b0, "reject cleared");
        @(posedge clk) busy[2] <= 1'b0;
        repeat (4) @(posedge clk);
        i_host.service(sv);
        chk(sv === 8'h04 && sum === 8'h00, "service");
        finish_test();
    end
    // Watchdog for a hung handshake
    initial begin
        #100us;
        mismatches++;
        finish_test();
    end
endmodule : test_ltf_flag_latches
